// file: wdt_pkg.sv
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase
    localparam int unsigned CLOCK_HZ        = 25_000_000;
    localparam int unsigned TICK_US         = 100;
    localparam int unsigned TICK_CYCLES     = CLOCK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned TICK_W          = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // Input filtering, 300 ns least pulse, 100 ns glitch immunity
    localparam int unsigned KICK_FILTER_NS  = 200;
    localparam int unsigned KICK_FILTER_CYC = (KICK_FILTER_NS * 25 + 999) / 1000;
    localparam int unsigned MR_FILTER_NS    = 400;
    localparam int unsigned MR_FILTER_CYC   = (MR_FILTER_NS * 25 + 999) / 1000;
    localparam int unsigned FILTER_W        = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Durations in ticks of TICK_US
    localparam int unsigned FAULT_PULSE_US  = 1000;
    localparam int unsigned FAULT_TICKS     = FAULT_PULSE_US / TICK_US;
    localparam int unsigned STRETCH_MS      = 180;
    localparam int unsigned STRETCH_TICKS   = STRETCH_MS * 1000 / TICK_US;
    localparam int unsigned WD_TIMER_W      = 20;

    // Fast limit at its longest and slow limit at its shortest per option, in 100 us ticks
    // Wide enough for the 60 s slow option
    localparam int unsigned WINDOW_OPTIONS  = 8;
    typedef logic [WD_TIMER_W-1:0] ticks_type;
    localparam ticks_type FAST_TICKS [WINDOW_OPTIONS] = '{
        20'd15, 20'd150, 20'd150, 20'd150, 20'd150, 20'd230, 20'd390, 20'd7190};
    localparam ticks_type SLOW_TICKS [WINDOW_OPTIONS] = '{
        20'd100, 20'd1000, 20'd3000, 20'd100000, 20'd600000, 20'd470, 20'd820, 20'd13000};

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic supply_good;
        logic manual_reset_n;
        logic watchdog_kick_in;
    } pins_in_type;

    typedef struct packed {
        logic reset_out_n;
        logic watchdog_fault_pulse_n;
        logic fast_fault;
        logic slow_fault;
    } pins_out_type;

endpackage

// file: input_filter.sv
module input_filter
    import wdt_pkg::*;
#(
    parameter int unsigned SETTLE = 4,
    parameter logic        INIT   = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic raw,
    output logic      level,
    output logic      fell
);
    typedef struct packed {
        logic                sync1;
        logic                sync2;
        logic                stable;
        logic [FILTER_W-1:0] count;
        logic                fell;
    } state_type;

    state_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = raw;
        s_d.sync2 = s_q.sync1;
        s_d.fell = 1'b0;
        // Only a level held SETTLE cycles is taken; short glitches vanish
        if (s_q.sync2 == s_q.stable) begin
            s_d.count = '0;
        end else if (s_q.count == FILTER_W'(SETTLE - 1)) begin
            s_d.stable = s_q.sync2;
            s_d.count = '0;
            s_d.fell = ~s_q.sync2;
        end else begin
            s_d.count = s_q.count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{sync1: INIT, sync2: INIT, stable: INIT, count: '0, fell: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.stable;
    assign fell = s_q.fell;
endmodule

// file: tick_gen.sv
module tick_gen
    import wdt_pkg::*;
#(
    parameter int unsigned DIVIDE = TICK_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_b,
    output logic      tick
);
    typedef struct packed {
        logic [TICK_W-1:0] count;
        logic              tick;
    } state_type;

    state_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.count == TICK_W'(DIVIDE - 1)) begin
            s_d.count = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.count = s_q.count + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// file: windowed_watchdog_supervisor.sv
// Notes on behaviour
// - Early kick edge pulses fault low.
// - No kick by slow limit pulses fault.
// - First kick after release skips fast check.
// - Timer clears on valid kick and reset release.
// - Kick inside window is valid service.
// - Fault pulse lasts about one millisecond.
// - Faults only while reset output high.
// - Eight build-time fast/slow limit pairs.
// - Manual reset asserts reset, clears timer, fault.
// - Reset held 180 ms after manual release.
// - Supply not good asserts reset, then stretch.
// - Kicks ignored during reset or fault.
// - Reset stretch at least 100 ms after release.
module windowed_watchdog_supervisor
    import wdt_pkg::*;
#(
    parameter int unsigned WINDOW_SELECT = 0,
    parameter int unsigned TICK_DIVIDE   = TICK_CYCLES,
    parameter int unsigned STRETCH       = STRETCH_TICKS,
    parameter int unsigned FAULT_LEN     = FAULT_TICKS
) (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire wdt_pkg::pins_in_type pins_in,
    output wdt_pkg::pins_out_type     pins_out
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Limits
    localparam ticks_type FAST_LIMIT = FAST_TICKS[WINDOW_SELECT];
    localparam ticks_type SLOW_LIMIT = SLOW_TICKS[WINDOW_SELECT];
    localparam int unsigned STRETCH_W = 16;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_STRETCH,
        ST_WATCH,
        ST_FAULT
    } mode_type;

    typedef struct packed {
        mode_type               mode;
        logic [STRETCH_W-1:0]   stretch;
        ticks_type              timer;
        logic [WD_TIMER_W-1:0]  pulse;
        logic                   first_kick;
        logic                   reset_n;
        logic                   fault_n;
        logic                   fast_fault;
        logic                   slow_fault;
    } state_type;

    state_type s_q, s_d;

    logic tick;
    logic kick_level;
    logic kick_fell;
    logic mr_level;

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase and input conditioning
    tick_gen #(
        .DIVIDE (TICK_DIVIDE)
    ) u_tick (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick)
    );

    input_filter #(
        .SETTLE (KICK_FILTER_CYC),
        .INIT   (1'b1)
    ) u_kick (
        .clock (clock),
        .rst_b (rst_b),
        .raw   (pins_in.watchdog_kick_in),
        .level (kick_level),
        .fell  (kick_fell)
    );

    // Shorter than the filter is rejected; the 1 us minimum keeps margin
    input_filter #(
        .SETTLE (MR_FILTER_CYC),
        .INIT   (1'b1)
    ) u_mr (
        .clock (clock),
        .rst_b (rst_b),
        .raw   (pins_in.manual_reset_n),
        .level (mr_level),
        .fell  ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Supervisor
    always_comb begin
        s_d = s_q;
        s_d.fast_fault = 1'b0;
        s_d.slow_fault = 1'b0;
        // Supply loss or manual reset overrides everything
        if (!pins_in.supply_good || !mr_level) begin
            s_d.mode = ST_RESET;
            s_d.reset_n = 1'b0;
            s_d.fault_n = 1'b1;
            s_d.timer = '0;
            s_d.stretch = '0;
            s_d.pulse = '0;
        end else begin
            case (s_q.mode)
                ST_RESET: begin
                    s_d.mode = ST_STRETCH;
                    s_d.stretch = '0;
                end
                ST_STRETCH: begin
                    // Counted in ticks; phase of the first tick takes off under one tick
                    if (tick) begin
                        s_d.stretch = s_q.stretch + 1'b1;
                    end
                    if (tick && s_q.stretch == STRETCH_W'(STRETCH - 1)) begin
                        s_d.mode = ST_WATCH;
                        s_d.reset_n = 1'b1;
                        s_d.timer = '0;
                        s_d.first_kick = 1'b1;
                    end
                end
                ST_WATCH: begin
                    if (kick_fell) begin
                        if (s_q.timer < FAST_LIMIT && !s_q.first_kick) begin
                            s_d.mode = ST_FAULT;
                            s_d.fault_n = 1'b0;
                            s_d.fast_fault = 1'b1;
                            s_d.pulse = '0;
                        end else begin
                            s_d.timer = '0;
                            s_d.first_kick = 1'b0;
                        end
                    end else if (tick) begin
                        if (s_q.timer == SLOW_LIMIT - 1'b1) begin
                            s_d.mode = ST_FAULT;
                            s_d.fault_n = 1'b0;
                            s_d.slow_fault = 1'b1;
                            s_d.pulse = '0;
                        end else begin
                            s_d.timer = s_q.timer + 1'b1;
                        end
                    end
                end
                ST_FAULT: begin
                    // Kick edges are dropped for the whole pulse
                    if (tick) begin
                        s_d.pulse = s_q.pulse + 1'b1;
                    end
                    if (tick && s_q.pulse == WD_TIMER_W'(FAULT_LEN - 1)) begin
                        s_d.mode = ST_WATCH;
                        s_d.fault_n = 1'b1;
                        s_d.timer = '0;
                        s_d.first_kick = 1'b1;
                    end
                end
                default: begin
                    s_d.mode = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{mode: ST_RESET, stretch: '0, timer: '0, pulse: '0, first_kick: 1'b1,
                     reset_n: 1'b0, fault_n: 1'b1, fast_fault: 1'b0, slow_fault: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // One driver for the whole carrier
    assign pins_out = '{reset_out_n: s_q.reset_n, watchdog_fault_pulse_n: s_q.fault_n,
                        fast_fault: s_q.fast_fault, slow_fault: s_q.slow_fault};
endmodule

// file: wdt_monitor.sv
module wdt_monitor
    import wdt_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  rst_b,
    input wire wdt_pkg::pins_in_type  pins_in,
    input wire wdt_pkg::pins_out_type pins_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_quiet_in_reset: assert property (!pins_out.reset_out_n
        && $past(!pins_out.reset_out_n)
        |-> pins_out.watchdog_fault_pulse_n) else $error("fault during reset");
    a_fast_drives_pin: assert property (pins_out.fast_fault
        |-> !pins_out.watchdog_fault_pulse_n) else $error("fast flag without pulse");
    a_slow_drives_pin: assert property (pins_out.slow_fault
        |-> !pins_out.watchdog_fault_pulse_n) else $error("slow flag without pulse");
    a_flag_single: assert property (pins_out.fast_fault || pins_out.slow_fault
        |=> !pins_out.fast_fault && !pins_out.slow_fault) else $error("flag too long");
    a_fault_cause: assert property ($fell(pins_out.watchdog_fault_pulse_n)
        |-> pins_out.fast_fault || pins_out.slow_fault) else $error("pulse without cause");
    a_pulse_length: assert property ($fell(pins_out.watchdog_fault_pulse_n)
        |-> !pins_out.watchdog_fault_pulse_n [*8] ##[1:12] pins_out.watchdog_fault_pulse_n)
        else $error("pulse length off");
    a_manual_holds: assert property (!pins_in.manual_reset_n [*8] ##1
        !pins_in.manual_reset_n [*8] |-> !pins_out.reset_out_n) else $error("manual ignored");
    a_supply_holds: assert property (!pins_in.supply_good [*4]
        |-> !pins_out.reset_out_n) else $error("supply loss ignored");
    a_stretch_held: assert property ($rose(pins_out.reset_out_n)
        |-> $past(pins_in.manual_reset_n, 16) && $past(pins_in.supply_good, 16))
        else $error("reset released early");
    a_kick_ignored: assert property (!pins_out.watchdog_fault_pulse_n
        && $past(!pins_out.watchdog_fault_pulse_n) |-> !pins_out.fast_fault)
        else $error("fault restarted in pulse");
endmodule

bind windowed_watchdog_supervisor wdt_monitor mon (.clock(clock), .rst_b(rst_b),
    .pins_in(pins_in), .pins_out(pins_out));

// file: kick_host.sv
module kick_host (
    input wire logic        clock,
    input wire logic        enable,
    input wire logic [15:0] period,
    output logic            kick
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] count_q;
    initial begin
        count_q = 16'h0;
        kick = 1'b1;
    end
    // Low ten cycles each period, well above the least pulse width
    always @(posedge clock) begin
        count_q <= #1 (!enable || count_q >= period - 16'h1) ? 16'h0 : count_q + 16'h1;
        kick <= #1 !(enable && count_q < 16'h000a);
    end
endmodule

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import wdt_pkg::*;
    logic         clock, rst_b, supply_good, mr_n, kick, kick_on;
    logic [15:0]  period;
    pins_in_type  pins_in;
    pins_out_type pins_out;
    int           errors, n_checks, n;

    assign pins_in = '{supply_good, mr_n, kick};
    // Short tick and stretch keep the run small
    windowed_watchdog_supervisor #(.TICK_DIVIDE(4), .STRETCH(5), .FAULT_LEN(3)) dut (
        .clock(clock), .rst_b(rst_b), .pins_in(pins_in), .pins_out(pins_out));
    kick_host host (.clock(clock), .enable(kick_on), .period(period), .kick(kick));

    ////////////////////////////////////////////////////////////////////////////////
    task cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task check(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wait_out(input int idx, input logic v, input int lim);
        n = 0;
        while (pins_out[idx] !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task power_up;
        cyc(10);
        check(pins_out.reset_out_n, 1'b0);
        wait_out(3, 1'b1, 100);
        check(n < 100, 1'b1);
    endtask
    task service;
        kick_on = 1'b1;
        wait_out(2, 1'b0, 1500);
        check(n == 1500, 1'b1);
    endtask
    task fast_then_slow;
        period = 16'd30;
        wait_out(1, 1'b1, 300);
        kick_on = 1'b0;
        check(n < 300, 1'b1);
        check(pins_out.watchdog_fault_pulse_n, 1'b0);
        wait_out(2, 1'b1, 40);
        check(n >= 7 && n <= 13, 1'b1);
        wait_out(0, 1'b1, 500);
        check(n >= 380 && n <= 420, 1'b1);
    endtask
    task manual;
        mr_n = 1'b0;
        cyc(26);
        check(pins_out.reset_out_n, 1'b0);
        check(pins_out.watchdog_fault_pulse_n, 1'b1);
        mr_n = 1'b1;
        wait_out(3, 1'b1, 200);
        check(n >= 20 && n < 200, 1'b1);
        mr_n = 1'b0;
        cyc(5);
        mr_n = 1'b1;
        cyc(20);
        check(pins_out.reset_out_n, 1'b1);
    endtask
    task supply;
        supply_good = 1'b0;
        cyc(6);
        check(pins_out.reset_out_n, 1'b0);
        supply_good = 1'b1;
        wait_out(3, 1'b1, 200);
        check(n >= 16 && n < 200, 1'b1);
        wait_out(0, 1'b1, 500);
        check(n >= 380 && n <= 420, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        rst_b = 1'b0;
        supply_good = 1'b1;
        mr_n = 1'b1;
        kick_on = 1'b0;
        period = 16'd200;
        errors = 0;
        n_checks = 0;
        cyc(8);
        rst_b = 1'b1;
        power_up;
        service;
        fast_then_slow;
        manual;
        supply;
        conclude;
    end
    // A hang ends the run at about 2.4 times the expected length
    initial begin
        repeat (6000) @(posedge clock);
        errors++;
        conclude;
    end
endmodule
